// ### verilog/cpfs_consts.vh
// Constants for the CPU power-fail sequencer: clock period, interval times,
// derived cycle counts helpers and state encodings.
// Assumes a single 20 MHz reference clock; times are given in their own unit.
`ifndef CPFS_CONSTS_VH
`define CPFS_CONSTS_VH

// ===========================================================================
// Clock and interval times
`define CPFS_CLK_NS 50
`define CPFS_GLITCH_NS 100
`define CPFS_MIN_ASSERT_US 5
`define CPFS_ONE_US 1
`define CPFS_LINE_HOLD_MS 5
`define CPFS_OUT_CLEAR_MS 3
`define CPFS_LINE_CLEAR_MS 70
`define CPFS_OSC_HOLD_MS 100
`define CPFS_DCOK_GOOD_MS 3
`define CPFS_POK_HOLD_MS 70
`define CPFS_POK_LOW_MS 3
`define CPFS_DCOK_LAG_MS 4
`define CPFS_NS_PER_US 1000
`define CPFS_NS_PER_MS 1000000

// ===========================================================================
// Main sequencer states
`define CPFS_SQ_IDLE 3'h0
`define CPFS_SQ_LINE 3'h1
`define CPFS_SQ_FAKE 3'h2
`define CPFS_SQ_OUTLOW 3'h3
`define CPFS_SQ_CLR_OUT 3'h4
`define CPFS_SQ_CLR_LINE 3'h5

// ===========================================================================
// Console bus states
`define CPFS_CS_DOWN 2'h0
`define CPFS_CS_DCOK 2'h1
`define CPFS_CS_UP 2'h2
`define CPFS_CS_PLOW 2'h3

// ===========================================================================
// Backplane extension states
`define CPFS_BP_IDLE 2'h0
`define CPFS_BP_SEEN 2'h1
`define CPFS_BP_HOLD 2'h2
`define CPFS_BP_TAIL 2'h3

`endif

// ### verilog/cpfs_pf_filter.v
// Synchroniser and deassertion filter for received power-fail signals.
// Assumes asynchronous active-high inputs; output is registered.
`default_nettype none

module cpfs_pf_filter #(
    parameter WIDTH = 1,
    parameter FILT = 2,
    parameter CW = 3
) (
    input wire ref_clk, // Reference clock.
    input wire reset, // Asynchronous reset, active high.
    input wire [WIDTH-1:0] raw_in, // Raw asynchronous inputs.
    output wire [WIDTH-1:0] filt_out // Synchronised, filtered inputs.
);

    // =======================================================================
    // Per-bit chain
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            reg s1_reg;
            reg s2_reg;
            reg s3_reg;
            reg out_reg;
            reg [CW-1:0] cnt_reg;
            always @(posedge ref_clk or posedge reset)
            begin
                if (reset)
                begin
                    s1_reg <= 1'h0;
                    s2_reg <= 1'h0;
                    s3_reg <= 1'h0;
                    out_reg <= 1'h0;
                    cnt_reg <= {CW{1'b0}};
                end
                else
                begin
                    s1_reg <= raw_in[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    // A bus driver letting go redistributes current; only a
                    // release that outlasts the filter window counts.
                    if (s2_reg && s3_reg)
                    begin
                        out_reg <= 1'h1;
                        cnt_reg <= {CW{1'b0}};
                    end
                    else if (!s2_reg && !s3_reg)
                    begin
                        if (cnt_reg >= FILT[CW-1:0])
                            out_reg <= 1'h0;
                        else
                            cnt_reg <= cnt_reg + 1'b1;
                    end
                end
            end
            assign filt_out[i] = out_reg;
        end
    endgenerate

endmodule // cpfs_pf_filter

`default_nettype wire

// ### verilog/cpfs_sequencer.v
// CPU power-fail sequencer: combines supply and backplane power-fail inputs,
// drives system line-low, output-low, console bus lines and backplane extension.
// Assumes supplies keep their own timing; all inputs are asynchronous pins.
`include "cpfs_consts.vh"
`default_nettype none

module cpfs_sequencer #(
    parameter NSUP = 3,
    parameter CW = 22,
    parameter [CW-1:0] T_LINE_HOLD =
        (`CPFS_LINE_HOLD_MS * `CPFS_NS_PER_MS + `CPFS_CLK_NS - 1) / `CPFS_CLK_NS,
    parameter [CW-1:0] T_OUT_CLEAR =
        (`CPFS_OUT_CLEAR_MS * `CPFS_NS_PER_MS + `CPFS_CLK_NS - 1) / `CPFS_CLK_NS,
    parameter [CW-1:0] T_LINE_CLEAR =
        (`CPFS_LINE_CLEAR_MS * `CPFS_NS_PER_MS + `CPFS_CLK_NS - 1) / `CPFS_CLK_NS,
    parameter [CW-1:0] T_OSC_HOLD =
        (`CPFS_OSC_HOLD_MS * `CPFS_NS_PER_MS + `CPFS_CLK_NS - 1) / `CPFS_CLK_NS,
    parameter [CW-1:0] T_DCOK_GOOD =
        (`CPFS_DCOK_GOOD_MS * `CPFS_NS_PER_MS + `CPFS_CLK_NS - 1) / `CPFS_CLK_NS,
    parameter [CW-1:0] T_POK_HOLD =
        (`CPFS_POK_HOLD_MS * `CPFS_NS_PER_MS + `CPFS_CLK_NS - 1) / `CPFS_CLK_NS,
    parameter [CW-1:0] T_POK_LOW =
        (`CPFS_POK_LOW_MS * `CPFS_NS_PER_MS + `CPFS_CLK_NS - 1) / `CPFS_CLK_NS,
    parameter [CW-1:0] T_DCOK_LAG =
        (`CPFS_DCOK_LAG_MS * `CPFS_NS_PER_MS + `CPFS_CLK_NS - 1) / `CPFS_CLK_NS
) (
    input wire ref_clk, // Reference clock, 20 MHz.
    input wire reset, // Asynchronous reset, active high.
    input wire [NSUP-1:0] sup_line_low, // Per-supply line-power-low.
    input wire [NSUP-1:0] sup_output_low, // Per-supply supply-output-low.
    input wire bp_warn_in, // Received backplane power-warning.
    input wire bp_gone_in, // Received backplane power-gone.
    input wire console_reset, // Console reset request.
    output wire line_power_low, // System line-power-low.
    output wire supply_output_low, // System supply-output-low.
    output wire console_bus_power_ok, // Console bus power-ok, high when good.
    output wire console_bus_dc_ok, // Console bus dc-ok, high when good.
    output wire bp_warn_drive, // Drive backplane power-warning.
    output wire bp_gone_drive, // Drive backplane power-gone.
    output wire power_fail_intr, // One-cycle power-fail interrupt.
    output wire system_init // System initialise.
);

    // =======================================================================
    // Short interval counts, all rounded up
    localparam [CW-1:0] T_ONE_US =
        (`CPFS_ONE_US * `CPFS_NS_PER_US + `CPFS_CLK_NS - 1) / `CPFS_CLK_NS;
    localparam [CW-1:0] T_MIN_ASSERT =
        (`CPFS_MIN_ASSERT_US * `CPFS_NS_PER_US + `CPFS_CLK_NS - 1) / `CPFS_CLK_NS;
    localparam FILT = (`CPFS_GLITCH_NS + `CPFS_CLK_NS - 1) / `CPFS_CLK_NS;

    // Count reached; used by all three machines.
    function reached;
        input [CW-1:0] cnt;
        input [CW-1:0] lim;
        begin
            reached = (cnt >= lim);
        end
    endfunction

    // =======================================================================
    // Input conditioning
    localparam NIN = 2 * NSUP + 3;
    wire [NIN-1:0] filt;

    cpfs_pf_filter #(
        .WIDTH(NIN),
        .FILT(FILT),
        .CW(3)
    ) u_filt (
        .ref_clk(ref_clk),
        .reset(reset),
        .raw_in({console_reset, bp_gone_in, bp_warn_in, sup_output_low, sup_line_low}),
        .filt_out(filt)
    );

    wire [NSUP-1:0] f_line = filt[NSUP-1:0];
    wire [NSUP-1:0] f_out = filt[2*NSUP-1:NSUP];
    wire f_warn = filt[2*NSUP];
    wire f_gone = filt[2*NSUP+1];
    wire f_creset = filt[2*NSUP+2];

    // Backplane warning and gone are line-low and output-low equivalents.
    wire line_or = (|f_line) | f_warn;
    wire out_or_ext = (|f_out) | f_gone;

    // =======================================================================
    // Main sequencer
    reg [2:0] sq_reg;
    reg [2:0] sq_next;
    reg [CW-1:0] sq_cnt_reg;
    reg [CW-1:0] sq_cnt_next;
    reg line_or_d_reg;
    reg intr_reg;
    reg intr_next;

    wire fake_out_low = (sq_reg == `CPFS_SQ_FAKE);
    wire out_or = out_or_ext | fake_out_low;
    wire pf_edge = line_or & ~line_or_d_reg;

    always @*
    begin
        sq_next = sq_reg;
        sq_cnt_next = sq_cnt_reg + 1'b1;
        intr_next = 1'b0;
        case (sq_reg)
            `CPFS_SQ_IDLE:
            begin
                sq_cnt_next = {CW{1'b0}};
                if (out_or_ext)
                begin
                    sq_next = `CPFS_SQ_OUTLOW;
                end
                else if (pf_edge)
                begin
                    // Edge triggered, so a held line-low gives one interrupt.
                    sq_next = `CPFS_SQ_LINE;
                    intr_next = 1'b1;
                end
            end
            `CPFS_SQ_LINE:
            begin
                if (out_or_ext)
                begin
                    sq_next = `CPFS_SQ_OUTLOW;
                    sq_cnt_next = {CW{1'b0}};
                end
                else if (reached(sq_cnt_reg, T_LINE_HOLD - 1'b1))
                begin
                    sq_next = `CPFS_SQ_FAKE;
                    sq_cnt_next = {CW{1'b0}};
                end
            end
            `CPFS_SQ_FAKE:
            begin
                // Internal output-low pulse forces both processors to init.
                if (reached(sq_cnt_reg, T_ONE_US - 1'b1))
                begin
                    sq_next = `CPFS_SQ_OUTLOW;
                    sq_cnt_next = {CW{1'b0}};
                end
            end
            `CPFS_SQ_OUTLOW:
            begin
                sq_cnt_next = {CW{1'b0}};
                if (!out_or)
                    sq_next = `CPFS_SQ_CLR_OUT;
            end
            `CPFS_SQ_CLR_OUT:
            begin
                if (out_or)
                begin
                    sq_next = `CPFS_SQ_OUTLOW;
                    sq_cnt_next = {CW{1'b0}};
                end
                else if (reached(sq_cnt_reg, T_OUT_CLEAR - 1'b1))
                begin
                    sq_next = `CPFS_SQ_CLR_LINE;
                    sq_cnt_next = {CW{1'b0}};
                end
            end
            `CPFS_SQ_CLR_LINE:
            begin
                if (out_or)
                begin
                    sq_next = `CPFS_SQ_OUTLOW;
                    sq_cnt_next = {CW{1'b0}};
                end
                else if (reached(sq_cnt_reg, T_LINE_CLEAR - 1'b1))
                begin
                    sq_next = `CPFS_SQ_IDLE;
                    sq_cnt_next = {CW{1'b0}};
                end
            end
            default:
            begin
                sq_next = `CPFS_SQ_IDLE;
                sq_cnt_next = {CW{1'b0}};
            end
        endcase
    end

    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            sq_reg <= `CPFS_SQ_IDLE;
            sq_cnt_reg <= {CW{1'b0}};
            line_or_d_reg <= 1'b0;
            intr_reg <= 1'b0;
        end
        else
        begin
            sq_reg <= sq_next;
            sq_cnt_reg <= sq_cnt_next;
            line_or_d_reg <= line_or;
            intr_reg <= intr_next;
        end
    end

    // Forced states are decoded from the sequencer; output-low sits inside
    // the line-low span, so the forced output-low never appears alone.
    wire forced_line_low = (sq_reg != `CPFS_SQ_IDLE);
    wire forced_output_low = (sq_reg == `CPFS_SQ_FAKE) ||
        (sq_reg == `CPFS_SQ_OUTLOW) || (sq_reg == `CPFS_SQ_CLR_OUT);
    wire sys_line_low = forced_line_low | line_or;
    wire sys_out_low = forced_output_low | out_or;

    // =======================================================================
    // Console bus power-ok and dc-ok
    reg [1:0] cs_reg;
    reg [1:0] cs_next;
    reg [CW-1:0] cs_cnt_reg;
    reg [CW-1:0] cs_cnt_next;

    always @*
    begin
        cs_next = cs_reg;
        cs_cnt_next = cs_cnt_reg + 1'b1;
        case (cs_reg)
            `CPFS_CS_DOWN:
            begin
                if (sys_out_low)
                    cs_cnt_next = {CW{1'b0}};
                else if (reached(cs_cnt_reg, T_DCOK_GOOD - 1'b1))
                begin
                    cs_next = `CPFS_CS_DCOK;
                    cs_cnt_next = {CW{1'b0}};
                end
            end
            `CPFS_CS_DCOK:
            begin
                // A power-down before power-up completes would hang the
                // console, so dc-ok is dropped and power-up starts over.
                if ((pf_edge || sys_out_low) &&
                    reached(cs_cnt_reg, T_ONE_US - 1'b1))
                begin
                    cs_next = `CPFS_CS_DOWN;
                    cs_cnt_next = {CW{1'b0}};
                end
                else if (!sys_line_low && reached(cs_cnt_reg, T_POK_HOLD - 1'b1))
                begin
                    cs_next = `CPFS_CS_UP;
                    cs_cnt_next = {CW{1'b0}};
                end
            end
            `CPFS_CS_UP:
            begin
                // Up is entered only after dc-ok held 70 ms.
                if (sys_line_low && reached(cs_cnt_reg, T_ONE_US - 1'b1))
                begin
                    cs_next = `CPFS_CS_PLOW;
                    cs_cnt_next = {CW{1'b0}};
                end
            end
            `CPFS_CS_PLOW:
            begin
                if (sys_out_low && reached(cs_cnt_reg, T_DCOK_LAG - 1'b1))
                begin
                    cs_next = `CPFS_CS_DOWN;
                    cs_cnt_next = {CW{1'b0}};
                end
                else if (!sys_line_low && !sys_out_low &&
                         reached(cs_cnt_reg, T_POK_LOW - 1'b1))
                begin
                    cs_next = `CPFS_CS_UP;
                    cs_cnt_next = {CW{1'b0}};
                end
                else if (reached(cs_cnt_reg, T_DCOK_LAG))
                begin
                    cs_cnt_next = cs_cnt_reg;
                end
            end
            default:
            begin
                cs_next = `CPFS_CS_DOWN;
                cs_cnt_next = {CW{1'b0}};
            end
        endcase
        // Saturate long waits so the counter never wraps back below a limit.
        if (cs_cnt_reg == {CW{1'b1}})
            cs_cnt_next = cs_cnt_reg;
    end

    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            cs_reg <= `CPFS_CS_DOWN;
            cs_cnt_reg <= {CW{1'b0}};
        end
        else
        begin
            cs_reg <= cs_next;
            cs_cnt_reg <= cs_cnt_next;
        end
    end

    // =======================================================================
    // Backplane power-return extension
    // Only received backplane gone starts this machine; supply faults inside
    // the CPU never reach the backplane drivers.
    reg [1:0] bp_reg;
    reg [1:0] bp_next;
    reg [CW-1:0] bp_cnt_reg;
    reg [CW-1:0] bp_cnt_next;

    always @*
    begin
        bp_next = bp_reg;
        bp_cnt_next = bp_cnt_reg + 1'b1;
        case (bp_reg)
            `CPFS_BP_IDLE:
            begin
                bp_cnt_next = {CW{1'b0}};
                if (f_gone)
                    bp_next = `CPFS_BP_SEEN;
            end
            `CPFS_BP_SEEN:
            begin
                bp_cnt_next = {CW{1'b0}};
                if (!f_gone)
                    bp_next = `CPFS_BP_HOLD;
            end
            `CPFS_BP_HOLD:
            begin
                // Oscillator start-up hold also gives the clock settle time.
                if (reached(bp_cnt_reg, T_OSC_HOLD - 1'b1))
                begin
                    bp_next = `CPFS_BP_TAIL;
                    bp_cnt_next = {CW{1'b0}};
                end
            end
            `CPFS_BP_TAIL:
            begin
                if (reached(bp_cnt_reg, T_MIN_ASSERT))
                begin
                    bp_next = `CPFS_BP_IDLE;
                    bp_cnt_next = {CW{1'b0}};
                end
            end
            default:
            begin
                bp_next = `CPFS_BP_IDLE;
                bp_cnt_next = {CW{1'b0}};
            end
        endcase
    end

    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            bp_reg <= `CPFS_BP_IDLE;
            bp_cnt_reg <= {CW{1'b0}};
        end
        else
        begin
            bp_reg <= bp_next;
            bp_cnt_reg <= bp_cnt_next;
        end
    end

    // =======================================================================
    // Registered outputs
    reg line_low_reg;
    reg out_low_reg;
    reg pok_reg;
    reg dcok_reg;
    reg bp_warn_reg;
    reg bp_gone_reg;
    reg init_reg;

    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            line_low_reg <= 1'b1;
            out_low_reg <= 1'b1;
            pok_reg <= 1'b0;
            dcok_reg <= 1'b0;
            bp_warn_reg <= 1'b0;
            bp_gone_reg <= 1'b0;
            init_reg <= 1'b1;
        end
        else
        begin
            // Line-low follows the forced span plus any supply, and holds until the console bus is up.
            line_low_reg <= sys_line_low | (cs_next != `CPFS_CS_UP);
            out_low_reg <= sys_out_low;
            pok_reg <= (cs_next == `CPFS_CS_UP);
            dcok_reg <= (cs_next != `CPFS_CS_DOWN);
            // Gone is only driven inside the warning span.
            bp_warn_reg <= (bp_next == `CPFS_BP_HOLD) || (bp_next == `CPFS_BP_TAIL);
            bp_gone_reg <= (bp_next == `CPFS_BP_HOLD);
            // Console reset touches only init, never the sequencer state.
            init_reg <= sys_out_low | f_creset;
        end
    end

    assign line_power_low = line_low_reg;
    assign supply_output_low = out_low_reg;
    assign console_bus_power_ok = pok_reg;
    assign console_bus_dc_ok = dcok_reg;
    assign bp_warn_drive = bp_warn_reg;
    assign bp_gone_drive = bp_gone_reg;
    assign power_fail_intr = intr_reg;
    assign system_init = init_reg;

endmodule // cpfs_sequencer

`default_nettype wire

// ### tb/cpfs_supply_model.sv
// Model of the CPU supplies that feed the power-fail sequencer.
// Assumes fail_req changes just after a rising clock edge.
`default_nettype none
module cpfs_supply_model #(
    parameter int NSUP = 3,
    parameter int LAG = 60,
    parameter int TAIL = 100
) (
    input wire logic ref_clk, // Clock.
    input wire logic [NSUP-1:0] fail_req, // Failure request.
    output logic [NSUP-1:0] line_low = '0, // Line-low.
    output logic [NSUP-1:0] output_low = '0 // Output-low.
);
    timeunit 1ns;
    timeprecision 1ps;
    int age [NSUP];
    int tail [NSUP];
    // =====
    // Line-low leads output-low and outlives it, as a healthy supply does.
    always @(posedge ref_clk)
    begin
        for (int i = 0; i < NSUP; i++)
        begin
            if (fail_req[i])
            begin
                line_low[i] <= 1'b1;
                age[i] <= age[i] + 1;
                if (age[i] >= LAG)
                    output_low[i] <= 1'b1;
                tail[i] <= TAIL;
            end
            else
            begin
                age[i] <= 0;
                output_low[i] <= 1'b0;
                if (tail[i] > 0)
                    tail[i] <= tail[i] - 1;
                else
                    line_low[i] <= 1'b0;
            end
        end
    end
endmodule // cpfs_supply_model
`default_nettype wire

// ### tb/cpfs_sequencer_assertions.sv
// Checker bound to the power-fail sequencer; sees its top ports only.
// Assumes the bind hands on the instance's interval parameters.
`default_nettype none
module cpfs_sequencer_assertions #(
    parameter int T_LINE_HOLD = 40,
    parameter int T_POK_HOLD = 50,
    parameter int T_DCOK_LAG = 35
) (
    input wire logic ref_clk, // Clock.
    input wire logic reset, // Reset.
    input wire logic line_power_low, // Line-low.
    input wire logic supply_output_low, // Output-low.
    input wire logic console_bus_power_ok, // Power-ok.
    input wire logic console_bus_dc_ok, // Dc-ok.
    input wire logic bp_warn_drive, // Warn drive.
    input wire logic bp_gone_drive, // Gone drive.
    input wire logic power_fail_intr // Interrupt.
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====
    // Saturating counts of how long each level has stood.
    logic [7:0] line_cnt, out_cnt, ok_cnt, plow_cnt;
    function automatic logic [7:0] inc(input logic [7:0] v);
        return (v == 8'hFF) ? v : v + 8'h01;
    endfunction
    // Output-low stands through reset, so its count restarts full.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            line_cnt <= 8'h00;
            out_cnt <= 8'hFF;
            ok_cnt <= 8'h00;
            plow_cnt <= 8'h00;
        end
        else
        begin
            line_cnt <= line_power_low ? inc(line_cnt) : 8'h00;
            out_cnt <= supply_output_low ? inc(out_cnt) : 8'h00;
            ok_cnt <= console_bus_dc_ok ? inc(ok_cnt) : 8'h00;
            plow_cnt <= console_bus_power_ok ? 8'h00 : inc(plow_cnt);
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    property p_gone_warn;
        bp_gone_drive |-> bp_warn_drive;
    endproperty
    a_gone_warn: assert property (p_gone_warn) else $error("gone without warn");
    property p_warn_tail;
        $fell(bp_gone_drive) |-> ##100 bp_warn_drive;
    endproperty
    a_warn_tail: assert property (p_warn_tail) else $error("warn tail short");
    property p_intr_line;
        power_fail_intr |-> ##[0:2] line_power_low;
    endproperty
    a_intr_line: assert property (p_intr_line) else $error("no line-low");
    property p_line_hold;
        $fell(line_power_low) |-> line_cnt >= T_LINE_HOLD;
    endproperty
    a_line_hold: assert property (p_line_hold) else $error("line-low short");
    property p_out_pulse;
        $fell(supply_output_low) |-> out_cnt >= 20;
    endproperty
    a_out_pulse: assert property (p_out_pulse) else $error("output-low short");
    property p_pok_rise;
        $rose(console_bus_power_ok) |-> console_bus_dc_ok && ok_cnt >= T_POK_HOLD - 1;
    endproperty
    a_pok_rise: assert property (p_pok_rise) else $error("power-ok early");
    property p_dcok_lag;
        $fell(console_bus_dc_ok) |-> plow_cnt >= T_DCOK_LAG - 1;
    endproperty
    a_dcok_lag: assert property (p_dcok_lag) else $error("dc-ok drop early");
    property p_out_in_line;
        supply_output_low |-> line_power_low;
    endproperty
    a_out_in_line: assert property (p_out_in_line) else $error("output-low alone");
    c_fail: cover property ($rose(power_fail_intr));
    c_gone: cover property ($fell(bp_gone_drive));
    c_dcok: cover property ($fell(console_bus_dc_ok));
endmodule // cpfs_sequencer_assertions
`default_nettype wire

// ### tb/cpfs_sequencer_tb.sv
// Self-checking bench for the power-fail sequencer, intervals shortened.
// Assumes the supply model and the checker are compiled first.
`default_nettype none
module cpfs_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [21:0] LH = 22'h28, OC = 22'h1E, LC = 22'h32, OSC = 22'h3C;
    localparam logic [21:0] DG = 22'h1E, PH = 22'h32, PL = 22'h1E, DL = 22'h23;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic warn_in = 1'b0;
    logic gone_in = 1'b0;
    logic con_rst = 1'b0;
    logic [2:0] fail_req = 3'h0;
    logic [2:0] sup_ll, sup_ol;
    logic lpl, sol, pok, dcok, bpw, bpg, intr, sinit;
    int fail_count = 0;
    int checks_done = 0;
    int n;
    always #25 ref_clk = ~ref_clk;
    cpfs_supply_model sup_u (.ref_clk(ref_clk), .fail_req(fail_req), .line_low(sup_ll),
        .output_low(sup_ol));
    cpfs_sequencer #(.T_LINE_HOLD(LH), .T_OUT_CLEAR(OC), .T_LINE_CLEAR(LC), .T_OSC_HOLD(OSC),
        .T_DCOK_GOOD(DG), .T_POK_HOLD(PH), .T_POK_LOW(PL), .T_DCOK_LAG(DL)) dut_u (
        .ref_clk(ref_clk), .reset(reset), .sup_line_low(sup_ll), .sup_output_low(sup_ol),
        .bp_warn_in(warn_in), .bp_gone_in(gone_in), .console_reset(con_rst),
        .line_power_low(lpl), .supply_output_low(sol), .console_bus_power_ok(pok),
        .console_bus_dc_ok(dcok), .bp_warn_drive(bpw), .bp_gone_drive(bpg),
        .power_fail_intr(intr), .system_init(sinit));
    // =====
    // Helpers
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic bad(input string what);
        fail_count++;
        $display("BAD %0t %s", $time, what);
    endtask
    task automatic check_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp)
            bad(what);
    endtask
    task automatic check_span(input int got, input int lo, input int hi, input string what);
        checks_done++;
        if (got < lo || got > hi)
            bad(what);
    endtask
    task automatic wait_until(ref logic sig, input logic val, input int lim, output int cnt);
        for (cnt = 0; cnt < lim && sig !== val; cnt++)
            step(1);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // =====
    // Scenarios
    task automatic t_power_up;
        wait_until(pok, 1'b1, 300, n);
        check_span(n, DG + PH - 2, DG + PH + 8, "power-ok rise");
        check_bit(dcok, 1'b1, "dc-ok");
        step(2);
        check_bit(lpl, 1'b0, "line-low release");
    endtask
    task automatic t_supply_fail;
        fail_req = 3'h3;
        wait_until(intr, 1'b1, 20, n);
        check_span(n, 2, 8, "interrupt");
        step(2);
        check_bit(lpl, 1'b1, "line-low");
        wait_until(sol, 1'b1, 100, n);
        check_span(n, LH - 8, LH + 2, "forced output-low");
        // Power-ok only drops once the console has been up for 1 us.
        check_bit(pok, 1'b0, "power-ok drop");
        step(120);
        fail_req = 3'h2;
        // The survivor must keep everything down well past every clear delay.
        step(OC + LC + 130);
        check_bit(sol, 1'b1, "output-low held");
        check_bit(lpl, 1'b1, "line-low held");
        fail_req = 3'h0;
        wait_until(sol, 1'b0, 100, n);
        check_span(n, OC, OC + 10, "output-low clear");
        wait_until(lpl, 1'b0, 400, n);
        check_span(n, LC, 399, "line-low tail");
        check_bit(pok, 1'b1, "power-ok back");
    endtask
    task automatic t_backplane;
        warn_in = 1'b1;
        wait_until(intr, 1'b1, 20, n);
        check_span(n, 2, 8, "warn interrupt");
        step(LH + 5);
        gone_in = 1'b1;
        step(110);
        check_bit(bpg, 1'b0, "no own gone drive");
        gone_in = 1'b0;
        wait_until(bpg, 1'b1, 20, n);
        check_bit(bpw, 1'b1, "warn with gone");
        wait_until(bpg, 1'b0, OSC + 20, n);
        check_span(n, OSC - 2, OSC + 2, "gone extension");
        wait_until(bpw, 1'b0, 200, n);
        check_span(n, 101, 110, "warn tail");
        warn_in = 1'b0;
        wait_until(pok, 1'b1, 600, n);
        check_span(n, 1, 599, "recovery");
    endtask
    task automatic t_console_reset;
        con_rst = 1'b1;
        wait_until(sinit, 1'b1, 10, n);
        check_span(n, 1, 8, "init");
        check_bit(lpl, 1'b0, "sequencer undisturbed");
        con_rst = 1'b0;
        wait_until(sinit, 1'b0, 10, n);
        check_span(n, 1, 8, "init release");
    endtask
    task automatic t_restart;
        fail_req = 3'h1;
        step(1);
        fail_req = 3'h0;
        wait_until(dcok, 1'b0, 100, n);
        wait_until(dcok, 1'b1, 300, n);
        // A new fail while dc-ok waits for power-ok must restart the console.
        step(25);
        fail_req = 3'h1;
        step(1);
        fail_req = 3'h0;
        wait_until(dcok, 1'b0, 20, n);
        check_span(n, 2, 8, "dc-ok restart");
        wait_until(pok, 1'b1, 600, n);
        check_span(n, 1, 599, "restart recovery");
    endtask
    initial
    begin
        step(3);
        reset = 1'b0;
        t_power_up();
        t_supply_fail();
        t_backplane();
        t_console_reset();
        t_restart();
        stop_test();
    end
    initial
    begin
        repeat (4000) @(posedge ref_clk);
        bad("watchdog");
        stop_test();
    end
endmodule // cpfs_sequencer_tb
bind cpfs_sequencer cpfs_sequencer_assertions #(.T_LINE_HOLD(T_LINE_HOLD),
    .T_POK_HOLD(T_POK_HOLD), .T_DCOK_LAG(T_DCOK_LAG)) chk_u (.ref_clk(ref_clk),
    .reset(reset), .line_power_low(line_power_low), .supply_output_low(supply_output_low),
    .console_bus_power_ok(console_bus_power_ok), .console_bus_dc_ok(console_bus_dc_ok),
    .bp_warn_drive(bp_warn_drive), .bp_gone_drive(bp_gone_drive),
    .power_fail_intr(power_fail_intr));
`default_nettype wire
